// *** logic/fsld_top.sv ***
// fieldbus status lamp driver: two red lamps from fieldbus stack condition flags
// assumes condition flags may be asynchronous; lamp outputs high means lit
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - two lamps: system fault and bus fault
// - system lamp dark; ident blinks 1 Hz 3 s
// - system lamp steady on any diagnostic fault, except while ident blinks
// - bus lamp dark without bus error
// - bus lamp steady: unconfigured, link error, no link
// - bus lamp blinks 2 Hz without cyclic data, unless it is steady
module fsld_top
    import fsld_pkg::*;
#(
    parameter int unsigned IDENT_HALF  = IDENT_HALF_CYC,
    parameter int unsigned NODATA_HALF = NODATA_HALF_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire fsld_cond_t  cond_in,
    output var fsld_lamps_t  lamps
);

    typedef struct packed {
        fsld_cond_t       cond_s1;
        fsld_cond_t       cond_s2;
        logic             ident_prev;
        logic             ident_act;
        logic [CNT_W-1:0] ident_cnt;
        logic [PH_W-1:0]  ident_ph;
        logic [CNT_W-1:0] nd_cnt;
        logic             nd_ph;
        fsld_lamps_t      lamps;
    } fsld_state_t;

    // lamp modes, one-hot codes
    typedef enum logic [2:0] {
        SYS_DARK   = 3'b001,
        SYS_STEADY = 3'b010,
        SYS_IDENT  = 3'b100
    } fsld_sys_mode_t;

    typedef enum logic [2:0] {
        BUS_DARK   = 3'b001,
        BUS_STEADY = 3'b010,
        BUS_BLINK  = 3'b100
    } fsld_bus_mode_t;

    // true on the last cycle of a half period
    function automatic logic half_end(
        input logic [CNT_W-1:0] cnt,
        input int unsigned      half
    );
        return cnt == CNT_W'(half - 1);
    endfunction

    // next value of a half-period counter, wrapping at its end
    function automatic logic [CNT_W-1:0] half_step(
        input logic [CNT_W-1:0] cnt,
        input int unsigned      half
    );
        if (half_end(cnt, half)) begin
            return '0;
        end
        return cnt + CNT_W'(1);
    endfunction

    // any diagnostic condition that keeps the system lamp steady
    function automatic logic sys_fault_of(
        input fsld_cond_t c
    );
        return c.watchdog_timeout | c.channel_diag | c.general_diag | c.system_error;
    endfunction

    // missing configuration or link keeps the bus lamp steady
    function automatic logic bus_steady_of(
        input fsld_cond_t c
    );
        return !c.configured | c.link_error | !c.link_up;
    endfunction

    fsld_state_t    s_q;
    fsld_state_t    s_d;
    // kept apart from s_q: it is the reset of s_q itself
    logic [1:0]     rst_sync_q;
    logic           rst_sync_n;
    logic           sys_fault;
    logic           bus_steady;
    logic           bus_blink;
    fsld_sys_mode_t sys_mode;
    fsld_bus_mode_t bus_mode;

    // reset released through two flops, asserted immediately
    // an unsynchronised release could split the counters across two edges
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_sync_q[1];

    always_comb begin
        s_d = s_q;
        // flags pass two flops before use
        s_d.cond_s1    = cond_in;
        s_d.cond_s2    = s_q.cond_s1;
        s_d.ident_prev = s_q.cond_s2.ident_request;

        sys_fault  = sys_fault_of(s_q.cond_s2);
        bus_steady = bus_steady_of(s_q.cond_s2);
        bus_blink  = !s_q.cond_s2.cyclic_data;

        if (s_q.cond_s2.ident_request && !s_q.ident_prev) begin
            // a new request restarts the 3 s window
            s_d.ident_act = 1'b1;
            s_d.ident_cnt = '0;
            s_d.ident_ph  = '0;
        end else if (s_q.ident_act) begin
            s_d.ident_cnt = half_step(s_q.ident_cnt, IDENT_HALF);
            if (half_end(s_q.ident_cnt, IDENT_HALF)) begin
                if (s_q.ident_ph == PH_W'(IDENT_PHASES - 1)) begin
                    s_d.ident_act = 1'b0;
                    s_d.ident_ph  = '0;
                end else begin
                    s_d.ident_ph = s_q.ident_ph + PH_W'(1);
                end
            end
        end

        // free-running 2 Hz timebase
        // never restarted, so the first half of a blink may be short
        s_d.nd_cnt = half_step(s_q.nd_cnt, NODATA_HALF);
        if (half_end(s_q.nd_cnt, NODATA_HALF)) begin
            s_d.nd_ph = !s_q.nd_ph;
        end

        if (s_q.ident_act) begin
            sys_mode = SYS_IDENT;
        end else if (sys_fault) begin
            sys_mode = SYS_STEADY;
        end else begin
            sys_mode = SYS_DARK;
        end

        if (bus_steady) begin
            bus_mode = BUS_STEADY;
        end else if (bus_blink) begin
            bus_mode = BUS_BLINK;
        end else begin
            bus_mode = BUS_DARK;
        end

        case (sys_mode)
            SYS_IDENT: begin
                s_d.lamps.system_fault_lamp = !s_q.ident_ph[0];
            end
            SYS_STEADY: begin
                s_d.lamps.system_fault_lamp = 1'b1;
            end
            default: begin
                s_d.lamps.system_fault_lamp = 1'b0;
            end
        endcase

        case (bus_mode)
            BUS_STEADY: begin
                s_d.lamps.bus_fault_lamp = 1'b1;
            end
            BUS_BLINK: begin
                s_d.lamps.bus_fault_lamp = !s_q.nd_ph;
            end
            default: begin
                s_d.lamps.bus_fault_lamp = 1'b0;
            end
        endcase
    end

    // both lamps registered
    // lamps come straight from flops, so no glitch reaches the panel
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_q.cond_s1    <= '0;
            s_q.cond_s2    <= '0;
            s_q.ident_prev <= 1'b0;
            s_q.ident_act  <= 1'b0;
            s_q.ident_cnt  <= '0;
            s_q.ident_ph   <= '0;
            s_q.nd_cnt     <= '0;
            s_q.nd_ph      <= 1'b0;
            s_q.lamps      <= '0;
        end else begin
            s_q.cond_s1    <= s_d.cond_s1;
            s_q.cond_s2    <= s_d.cond_s2;
            s_q.ident_prev <= s_d.ident_prev;
            s_q.ident_act  <= s_d.ident_act;
            s_q.ident_cnt  <= s_d.ident_cnt;
            s_q.ident_ph   <= s_d.ident_ph;
            s_q.nd_cnt     <= s_d.nd_cnt;
            s_q.nd_ph      <= s_d.nd_ph;
            s_q.lamps      <= s_d.lamps;
        end
    end

    assign lamps = s_q.lamps;

endmodule

`default_nettype wire

// *** include/fsld_pkg.sv ***
// package for the fieldbus status lamp driver: timing constants and carriers
// assumes a 100 MHz core clock
package fsld_pkg;

    localparam int unsigned CLK_HZ          = 100_000_000;
    // identification blink: 1 Hz for 3 s
    localparam int unsigned IDENT_BLINK_HZ  = 1;
    localparam int unsigned IDENT_TIME_S    = 3;
    // no-data blink: 2 Hz
    localparam int unsigned NODATA_BLINK_HZ = 2;
    // half periods give the 50 percent duty
    localparam int unsigned IDENT_HALF_CYC  = CLK_HZ / (2 * IDENT_BLINK_HZ);
    localparam int unsigned NODATA_HALF_CYC = CLK_HZ / (2 * NODATA_BLINK_HZ);
    // blink phases in the identification window
    localparam int unsigned IDENT_PHASES    = 2 * IDENT_BLINK_HZ * IDENT_TIME_S;
    localparam int unsigned CNT_W           = 32;
    localparam int unsigned PH_W            = 8;

    typedef struct packed {
        logic watchdog_timeout;
        logic channel_diag;
        logic general_diag;
        logic system_error;
        logic ident_request;
        logic configured;
        logic link_error;
        logic link_up;
        logic cyclic_data;
    } fsld_cond_t;

    typedef struct packed {
        logic system_fault_lamp;
        logic bus_fault_lamp;
    } fsld_lamps_t;

endpackage

// *** verif/fsld_chk_sva.sv ***
// port checker for the status lamp driver
// assumes half periods of 10 and 5 cycles
`timescale 1ns/1ps
`default_nettype none
module fsld_chk import fsld_pkg::*; #(
    parameter int unsigned IDENT_HALF  = 10,
    parameter int unsigned NODATA_HALF = 5
) (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire fsld_cond_t  cond_in,
    input wire fsld_lamps_t lamps
);
    logic [7:0] quiet_q, nd_q, run_q;
    wire logic sf = lamps.system_fault_lamp;
    wire logic bf = lamps.bus_fault_lamp;
    wire logic bad = !cond_in.configured || cond_in.link_error || !cond_in.link_up;
    wire logic dg = |cond_in[8:5];
    // wraps are harmless: they only pause checks
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            quiet_q <= 8'h00;
            nd_q <= 8'h00;
            run_q <= 8'h00;
        end else begin
            quiet_q <= cond_in.ident_request ? 8'h00 : quiet_q + 8'h01;
            nd_q <= (!bad && !cond_in.cyclic_data) ? nd_q + 8'h01 : 8'h00;
            run_q <= $changed(bf) ? 8'h01 : run_q + 8'h01;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence ident_go;
        $rose(cond_in.ident_request) ##[3:5] $rose(sf);
    endsequence
    sequence lit_half;
        sf [*8] ##1 sf [*2] ##1 !sf;
    endsequence
    chk_sys_steady: assert property (dg [*7] ##0 quiet_q > 8'h46 |-> sf)
        else $error("sys lamp dark");
    chk_sys_dark: assert property (!dg [*7] ##0 quiet_q > 8'h46 |-> !sf)
        else $error("sys lamp lit");
    chk_bus_steady: assert property (bad [*7] |-> bf)
        else $error("bus lamp dark");
    chk_bus_dark: assert property ((!bad && cond_in.cyclic_data) [*7] |-> !bf)
        else $error("bus lamp lit");
    chk_bus_blink: assert property ($changed(bf) && nd_q > 8'h0a |-> run_q == 8'(NODATA_HALF))
        else $error("bus blink half wrong");
    chk_ident_half: assert property (ident_go |-> lit_half)
        else $error("ident half wrong");
    chk_ident_over: assert property ($rose(cond_in.ident_request) |-> ##[3:16] !sf)
        else $error("ident no blink");
    chk_reset_dark: assert property (disable iff (1'b0) !rst_n |-> !sf && !bf)
        else $error("lamp lit in reset");
endmodule
bind fsld_top fsld_chk #(.IDENT_HALF(IDENT_HALF), .NODATA_HALF(NODATA_HALF)) u_fsld_chk (
    .core_clk(core_clk), .rst_n(rst_n), .cond_in(cond_in), .lamps(lamps));
`default_nettype wire

// *** verif/fsld_lamp_model.sv ***
// front-panel lamp pair: counts system lamp flashes
// assumes lamp high means lit
`timescale 1ns/1ps
`default_nettype none
module fsld_lamp_model import fsld_pkg::*; (
    input  wire logic        core_clk,
    input  wire fsld_lamps_t lamps,
    output logic [7:0]       sys_flashes
);
    logic sys_q = 1'b0;
    initial sys_flashes = 8'h00;
    always @(posedge core_clk) begin
        sys_flashes <= sys_flashes + {7'h00, lamps.system_fault_lamp & ~sys_q};
        sys_q <= lamps.system_fault_lamp;
    end
endmodule
`default_nettype wire

// *** verif/tb_fieldbus_status_lamp_driver.sv ***
// bench for the lamp driver: corner and random condition patterns
// assumes half periods shortened to 10 and 5 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_fieldbus_status_lamp_driver import fsld_pkg::*;;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b1;
    fsld_cond_t  cond_in = '0;
    fsld_lamps_t lamps;
    logic [7:0]  fl, f0, hs, hb;
    logic [31:0] sd = 32'h82ae;
    int          bad_count = 0;
    int          n_tests = 0;
    always #5 core_clk = ~core_clk;
    fsld_top #(.IDENT_HALF(10), .NODATA_HALF(5)) u_fsld_top (.core_clk(core_clk),
        .rst_n(rst_n), .cond_in(cond_in), .lamps(lamps));
    fsld_lamp_model u_fsld_lamp_model (.core_clk(core_clk), .lamps(lamps), .sys_flashes(fl));
    // lit samples expected in a 20-cycle window
    function automatic logic [7:0] hi_bus(input fsld_cond_t c);
        if (!c.configured || c.link_error || !c.link_up) return 8'h14;
        return c.cyclic_data ? 8'h00 : 8'h0a;
    endfunction
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic ident(input logic err);
        cond_in = '{configured:1'b1, link_up:1'b1, cyclic_data:1'b1, system_error:err,
            default:1'b0};
        repeat (100) @(negedge core_clk);
        f0 = fl;
        cond_in.ident_request = 1'b1;
        repeat (80) @(negedge core_clk);
        check(8'(fl - f0), 8'h03);
        check({7'h00, lamps.system_fault_lamp}, {7'h00, err});
        cond_in.ident_request = 1'b0;
    endtask
    initial begin
        #1 rst_n = 1'b0;
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        ident(1'b0);
        ident(1'b1);
        for (int i = 0; i < 48; i++) begin
            sd = lfsr_next(sd);
            cond_in = {sd[3:0] & {4{sd[4]}}, 1'b0, i[3:0]};
            repeat (8) @(negedge core_clk);
            hs = 8'h00;
            hb = 8'h00;
            repeat (20) begin
                @(negedge core_clk);
                hs += {7'h00, lamps.system_fault_lamp};
                hb += {7'h00, lamps.bus_fault_lamp};
            end
            check(hs, (|cond_in[8:5]) ? 8'h14 : 8'h00);
            check(hb, hi_bus(cond_in));
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
